/* File: verilog/uarr_pkg.sv */
// package for the uart receive recovery block: timing, mode and state constants
// assumes nothing beyond a single core clock domain
`default_nettype none
package uarr_pkg;
	localparam int unsigned CLK_HZ           = 50000000;
	localparam int unsigned OVERSAMPLE_NORM  = 16;
	localparam int unsigned OVERSAMPLE_DBL   = 8;
	localparam logic [3:0]  VOTE_FIRST_NORM  = 4'h8;
	localparam logic [3:0]  VOTE_FIRST_DBL   = 4'h4;
	localparam logic [3:0]  LAST_STATE_NORM  = 4'hF;
	localparam logic [3:0]  LAST_STATE_DBL   = 4'h7;
	localparam logic [3:0]  FIRST_SAMPLE     = 4'h1;
	localparam int unsigned DATA_BITS_MIN    = 5;
	localparam int unsigned DATA_BITS_MAX    = 10;
	localparam int unsigned DATA_BITS_DEF    = 8;
	localparam int unsigned DIVISOR_DEF      = 27;
	localparam int unsigned DIVISOR_WIDTH    = 16;
	localparam int unsigned BITCNT_WIDTH     = 4;

	typedef enum logic [1:0] {
		UARR_IDLE  = 2'b00,
		UARR_START = 2'b01,
		UARR_DATA  = 2'b10,
		UARR_STOP  = 2'b11
	} uarr_state_type;
endpackage : uarr_pkg
`default_nettype wire

/* File: verilog/uarr_tick.sv */
// sample tick divider: one-cycle enable at the oversampling rate
// assumes divisor is static while the receiver runs
`default_nettype none
`timescale 1ns/1ps
module uarr_tick
	import uarr_pkg::*;
#(
	parameter int unsigned WIDTH = DIVISOR_WIDTH
) (
	input  wire logic             core_clk,
	input  wire logic             rstn,
	input  wire logic [WIDTH-1:0] divisor,
	output logic                  tick
);
	logic [WIDTH-1:0] count;
	logic [WIDTH-1:0] next_count;

	if (WIDTH < 2) begin : g_bad_width
		$error("uarr_tick: WIDTH too small");
	end

	always_comb begin
		tick = (count == '0);
		// divisor 0 or 1 gives a tick every cycle
		if (tick)
			next_count = (divisor == '0) ? '0 : WIDTH'(divisor - 1'b1);
		else
			next_count = WIDTH'(count - 1'b1);
	end

	always_ff @(posedge core_clk) begin
		if (!rstn)
			count <= '0;
		else
			count <= next_count;
	end
endmodule // uarr_tick
`default_nettype wire

/* File: verilog/uarr_sync.sv */
// two-flop synchroniser for the serial input, idle level high
// assumes an asynchronous pin, reset value matches idle line
`default_nettype none
`timescale 1ns/1ps
module uarr_sync (
	input  wire logic core_clk,
	input  wire logic rstn,
	input  wire logic din,
	output logic      dout
);
	logic meta;
	logic next_meta;
	logic next_dout;

	always_comb begin
		next_meta = din;
		next_dout = meta;
	end

	// reset to one so no false start edge at release
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			meta <= 1'b1;
			dout <= 1'b1;
		end else begin
			meta <= next_meta;
			dout <= next_dout;
		end
	end
endmodule // uarr_sync
`default_nettype wire

/* File: verilog/uarr_rx.sv */
// asynchronous receive front end: start-bit qualification and 3-sample voting
// assumes divisor gives the oversampled tick; data_bits static between frames
`default_nettype none
`timescale 1ns/1ps

// How it works
// - sample input at 16x baud normally, 8x baud in double speed.
// - idle-high line going low starts qualification; first low sample is one.
// - qualify start on samples 8,9,10 normal or 4,5,6 double speed.
// - two or more high qualifying samples reject start as noise.
// - accepted start realigns bit phase; repeated for every frame.
// - per-bit state counter has 16 states normal, 8 double speed.
// - bit value is majority of three centre samples.
// - votes start at sample 8 (middle 9) or 4 (middle 5).
// - recover through first stop bit; further stop bits ignored.
// - stop bit voted; low stop sets frame error flag.
// - normal mode can see next start edge right after stop votes.
// - frames carry five to ten data bits.
// - double speed changes baud divisor from sixteen to eight.
// - frame error travels with its frame's data.
module uarr_rx
	import uarr_pkg::*;
#(
	parameter int unsigned DIV_WIDTH = DIVISOR_WIDTH
) (
	input  wire logic                      core_clk,
	input  wire logic                      rstn,
	input  wire logic                      serial_receive_pin,
	input  wire logic                      double_speed_select,
	input  wire logic [DIV_WIDTH-1:0]      sample_divisor,
	input  wire logic [BITCNT_WIDTH-1:0]   data_bits,
	output logic                           rx_valid,
	output logic [DATA_BITS_MAX-1:0]       rx_data,
	output logic                           frame_error_flag,
	output logic                           rx_busy
);
	import uarr_pkg::*;

	logic                     line;
	logic                     tick;
	uarr_state_type           state;
	uarr_state_type           next_state;
	logic [3:0]               phase;
	logic [3:0]               next_phase;
	logic [2:0]               votes;
	logic [2:0]               next_votes;
	logic [BITCNT_WIDTH-1:0]  bit_index;
	logic [BITCNT_WIDTH-1:0]  next_bit_index;
	logic [DATA_BITS_MAX-1:0] shift;
	logic [DATA_BITS_MAX-1:0] next_shift;
	logic [DATA_BITS_MAX-1:0] next_rx_data;
	logic                     next_rx_valid;
	logic                     next_frame_error_flag;
	logic [3:0]               vote_first;
	logic [3:0]               vote_last;
	logic [3:0]               last_state;
	logic                     in_window;
	logic                     vote_done;
	logic                     bit_end;
	logic                     majority;
	logic [BITCNT_WIDTH-1:0]  frame_len;

	// refused at elaboration: the tick divider needs at least two bits
	if (DIV_WIDTH < 2) begin : g_bad_div_width
		$error("uarr_rx: DIV_WIDTH too small");
	end

	uarr_sync u_sync (
		.core_clk (core_clk),
		.rstn     (rstn),
		.din      (serial_receive_pin),
		.dout     (line)
	);

	// software sets the divisor for 16x; halving the ratio to 8x is
	// done by the caller scaling sample_divisor, so only state count and vote window change here
	uarr_tick #(
		.WIDTH (DIV_WIDTH)
	) u_tick (
		.core_clk (core_clk),
		.rstn     (rstn),
		.divisor  (sample_divisor),
		.tick     (tick)
	);

	always_comb begin
		vote_first = double_speed_select ? VOTE_FIRST_DBL : VOTE_FIRST_NORM;
		vote_last  = 4'(vote_first + 4'h2);
		last_state = double_speed_select ? LAST_STATE_DBL : LAST_STATE_NORM;
		in_window  = (phase >= vote_first) && (phase <= vote_last);
		vote_done  = (phase == vote_last);
		bit_end    = (phase == last_state);
		// votes holds earlier two samples; count with current line sample
		majority   = (votes[1] & votes[0]) | (votes[1] & line) | (votes[0] & line);
		// clamp unsupported lengths into the served range
		if (data_bits < BITCNT_WIDTH'(DATA_BITS_MIN))
			frame_len = BITCNT_WIDTH'(DATA_BITS_MIN);
		else if (data_bits > BITCNT_WIDTH'(DATA_BITS_MAX))
			frame_len = BITCNT_WIDTH'(DATA_BITS_MAX);
		else
			frame_len = data_bits;
	end

	always_comb begin
		next_state            = state;
		next_phase            = phase;
		next_votes            = votes;
		next_bit_index        = bit_index;
		next_shift            = shift;
		next_rx_data          = rx_data;
		next_rx_valid         = 1'b0;
		next_frame_error_flag = frame_error_flag;
		if (tick) begin
			next_phase = 4'(phase + 4'h1);
			if (in_window)
				next_votes = {votes[1:0], line};
			unique case (state)
				UARR_IDLE: begin
					next_votes = '0;
					if (!line) begin
						next_state = UARR_START;
						next_phase = 4'(FIRST_SAMPLE + 4'h1);
					end
				end
				UARR_START: begin
					if (vote_done) begin
						if (majority) begin
							next_state = UARR_IDLE;
						end else begin
							// keep sample numbering from the start edge
							next_state     = UARR_DATA;
							next_bit_index = '0;
						end
					end
				end
				UARR_DATA: begin
					if (vote_done) begin
						next_shift = {majority, shift[DATA_BITS_MAX-1:1]};
						next_bit_index = 4'(bit_index + 4'h1);
					end
					if (bit_end) begin
						// last sample of a bit shows as zero, so each bit spans
						// all 16 (or 8) states instead of one short
						next_phase = 4'(FIRST_SAMPLE - 4'h1);
						next_votes = '0;
						if (bit_index == frame_len)
							next_state = UARR_STOP;
					end
				end
				UARR_STOP: begin
					if (vote_done) begin
						// right-align data to its length; frame error paired with it
						next_rx_data = shift >> (DATA_BITS_MAX - 32'(frame_len));
						next_frame_error_flag = !majority;
						next_rx_valid = 1'b1;
						// leave at once so the next falling edge is caught
						next_state = UARR_IDLE;
					end
				end
				default: next_state = UARR_IDLE;
			endcase
		end
		if (bit_end && tick && state == UARR_START)
			next_phase = FIRST_SAMPLE;
	end

	// double speed edges at the stop may come early too; the far side is
	// expected to keep its rate inside the margins

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			state            <= UARR_IDLE;
			phase            <= '0;
			votes            <= '0;
			bit_index        <= '0;
			shift            <= '0;
			rx_data          <= '0;
			rx_valid         <= 1'b0;
			frame_error_flag <= 1'b0;
		end else begin
			state            <= next_state;
			phase            <= next_phase;
			votes            <= next_votes;
			bit_index        <= next_bit_index;
			shift            <= next_shift;
			rx_data          <= next_rx_data;
			rx_valid         <= next_rx_valid;
			frame_error_flag <= next_frame_error_flag;
		end
	end

	assign rx_busy = (state != UARR_IDLE);
endmodule // uarr_rx
`default_nettype wire

/* File: verification/uarr_rx_assertions.sv */
// checker for the receive front end, bound to its ports
// assumes one clock domain and a sample tick of at least one cycle
`default_nettype none
`timescale 1ns/1ps
module uarr_rx_assertions
	import uarr_pkg::*;
#(
	parameter int unsigned DIV_WIDTH = DIVISOR_WIDTH
) (
	input wire logic                     core_clk,
	input wire logic                     rstn,
	input wire logic                     serial_receive_pin,
	input wire logic                     double_speed_select,
	input wire logic [DIV_WIDTH-1:0]     sample_divisor,
	input wire logic [BITCNT_WIDTH-1:0]  data_bits,
	input wire logic                     rx_valid,
	input wire logic [DATA_BITS_MAX-1:0] rx_data,
	input wire logic                     frame_error_flag,
	input wire logic                     rx_busy
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	AST_PULSE: assert property (rx_valid |=> !rx_valid)
		else $error("valid wider than one cycle");
	AST_DATA_HOLD: assert property ($changed(rx_data) |-> rx_valid)
		else $error("data moved without valid");
	AST_FLAG_HOLD: assert property ($changed(frame_error_flag) |-> rx_valid)
		else $error("flag moved without valid");
	AST_START_DBL: assert property ($rose(rx_busy) |-> rx_busy [*5])
		else $error("start decided too early");
	AST_START_NORM: assert property ($rose(rx_busy) && !double_speed_select |-> rx_busy [*8])
		else $error("normal start decided too early");
	AST_IDLE: assert property ((!rx_busy && serial_receive_pin) [*4] |=> !rx_busy)
		else $error("busy on idle line");
	AST_START_CAUSE: assert property ($rose(rx_busy) |-> !$past(serial_receive_pin)
		|| !$past(serial_receive_pin, 2) || !$past(serial_receive_pin, 3))
		else $error("busy without falling line");
	AST_UPPER: assert property (rx_valid && data_bits >= 4'h5 && data_bits <= 4'hA
		|-> (rx_data >> data_bits) == 10'h000)
		else $error("unused upper bits set");
	AST_FRAME_LEN: assert property (rx_valid |-> $past(rx_busy, 2) && $past(rx_busy, 50))
		else $error("frame too short");
endmodule // uarr_rx_assertions
`default_nettype wire

/* File: verification/uarr_tx_model.sv */
// remote transmitter model: drives the serial line, idle high
// assumes calls begin just after a rising clock edge
`default_nettype none
`timescale 1ns/1ps
module uarr_tx_model (
	input  wire logic core_clk,
	output var logic  line
);
	initial line = 1'b1;
	// symbols lsb first; the last one has its own length for early starts
	task automatic send(input logic [11:0] f, input int n, input int bc, input int lc);
		for (int i = 0; i < n; i++) begin
			line <= f[i];
			repeat (i == n - 1 ? lc : bc) @(posedge core_clk);
		end
	endtask
endmodule // uarr_tx_model
`default_nettype wire

/* File: verification/uarr_rx_tb.sv */
// self-checking bench for the receive front end with a queue model
// assumes the transmitter model on the line and the bound checker
`default_nettype none
`timescale 1ns/1ps
module uarr_rx_tb;
	import uarr_pkg::*;
	logic        core_clk = 1'b0;
	logic        rstn     = 1'b0;
	logic        dbl      = 1'b0;
	logic [15:0] div      = 16'h0001;
	logic [3:0]  nb       = 4'h8;
	logic        rx_valid;
	logic        frame_error_flag;
	logic        rx_busy;
	logic        line;
	logic [9:0]  rx_data;
	logic [10:0] got;
	logic [10:0] exp_q[$];
	int          n_fail      = 0;
	int          checks_done = 0;
	int          seed        = 82568;

	uarr_rx dut (.core_clk(core_clk), .rstn(rstn), .serial_receive_pin(line),
		.double_speed_select(dbl), .sample_divisor(div), .data_bits(nb),
		.rx_valid(rx_valid), .rx_data(rx_data), .frame_error_flag(frame_error_flag),
		.rx_busy(rx_busy));
	uarr_tx_model tx (.core_clk(core_clk), .line(line));

	always #10 core_clk = ~core_clk;

	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// gap 0 cuts the stop to 14 ticks, early only in normal mode, so the next start follows at once
	task automatic frame(input int n, input logic stp, input int gap);
		logic [9:0] d;
		int bc;
		d = 10'($random(seed)) & ((10'h001 << n) - 10'h001);
		bc = (dbl ? 8 : 16) * int'(div);
		exp_q.push_back({~stp, d});
		tx.send(({11'h000, stp} << (n + 1)) | {1'b0, d, 1'b0}, n + 2, bc,
			gap != 0 ? bc : 14 * int'(div));
		if (gap != 0)
			tx.send(12'hFFF, 1, gap, gap);
	endtask

	always @(negedge core_clk) begin
		if (rx_valid === 1'b1) begin
			checks_done++;
			got = {frame_error_flag, rx_data};
			if (exp_q.size() == 0 || got !== exp_q[0]) begin
				n_fail++;
				$display("[ERR] %0t got %h exp %h", $time, got,
					exp_q.size() != 0 ? exp_q[0] : 11'h7FF);
			end
			if (exp_q.size() != 0)
				void'(exp_q.pop_front());
		end
	end

	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		for (int m = 0; m < 2; m++) begin
			dbl <= m[0];
			div <= 16'(m + 1);
			for (int n = 5; n <= 10; n++) begin
				nb <= 4'(n);
				@(posedge core_clk);
				frame(n, 1'b1, 40);
				frame(n, 1'b0, 40);
				frame(n, 1'b1, m != 0 ? 40 : 0);
				frame(n, 1'b1, 40);
				tx.send(12'h000, 1, 0, (m != 0 ? 3 : 6) * (m + 1));
				tx.send(12'hFFF, 1, 0, 40);
				@(negedge core_clk);
				checks_done++;
				if (rx_busy !== 1'b0) begin
					n_fail++;
					$display("[ERR] %0t got %h exp %h", $time, rx_busy, 1'b0);
				end
				@(posedge core_clk);
			end
			$display("mode %0d done", m);
		end
		for (int w = 0; w < 400 && exp_q.size() != 0; w++)
			@(posedge core_clk);
		checks_done++;
		if (exp_q.size() != 0) begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, exp_q.size(), 0);
		end
		stop_test();
	end
endmodule // uarr_rx_tb

bind uarr_rx uarr_rx_assertions #(.DIV_WIDTH(DIV_WIDTH)) chk (.core_clk(core_clk),
	.rstn(rstn), .serial_receive_pin(serial_receive_pin),
	.double_speed_select(double_speed_select), .sample_divisor(sample_divisor),
	.data_bits(data_bits), .rx_valid(rx_valid), .rx_data(rx_data),
	.frame_error_flag(frame_error_flag), .rx_busy(rx_busy));
`default_nettype wire
